// ==== can_recovery_pkg.sv ====
// Constants and types shared by the bus-off recovery controller files.
package can_recovery_pkg;

	// ****************************************************************
	// Register offsets (byte addresses on the APB side)
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ECR = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_IE = 8'h10;
	localparam logic [7:0] OFS_RXTO = 8'h14;
	localparam logic [7:0] OFS_NTCC = 8'h18;
	localparam logic [7:0] OFS_BITCFG = 8'h1c;
	localparam logic [7:0] OFS_TT_A = 8'h20;
	localparam logic [7:0] OFS_TT_B = 8'h24;
	localparam logic [7:0] OFS_TT_C = 8'h28;
	localparam logic [7:0] OFS_RXBUF_LO = 8'h30;
	localparam logic [7:0] OFS_RXBUF_HI = 8'h34;
	localparam logic [7:0] OFS_RXINFO = 8'h38;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTRL_HALT_BIT = 0;
	localparam int CTRL_TXREQ_BIT = 1;
	localparam int ST_LEC_LSB = 0;
	localparam int ST_ACT_LSB = 3;
	localparam int ST_BO_BIT = 7;
	localparam int ECR_REC_LSB = 8;
	localparam int FL_PE = 0;
	localparam int FL_TO = 1;
	localparam int FL_NF = 2;
	localparam int FL_TT = 3;
	localparam int IE_PE = 0;
	localparam int IE_F0 = 1;
	localparam int IE_F1 = 2;
	localparam int IE_DB = 3;
	localparam int IE_TT = 4;
	localparam int RXTO_TEIE_BIT = 16;
	localparam int NTCC_SRC_BIT = 0;
	localparam int NTCC_PRE_LSB = 4;
	localparam int TT_GO_BIT = 31;

	// ****************************************************************
	// Reset values and counts
	// ****************************************************************
	localparam logic [15:0] BITCFG_RST = 16'h000a;
	localparam logic HALT_RST = 1'b1;
	localparam logic [3:0] IDLE_BITS = 4'hb;
	localparam logic [7:0] RECOV_OCC = 8'h81;
	localparam logic [2:0] LEC_BIT0 = 3'h5;
	localparam logic [8:0] TEC_ERR_STEP = 9'h008;
	localparam logic [8:0] TEC_LIMIT = 9'h0ff;
	localparam logic [7:0] REC_MAX = 8'h7f;
	localparam logic [3:0] BUF_BYTES = 4'h8;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {ACT_SYNC, ACT_IDLE, ACT_RX, ACT_TX} act_e;
	localparam logic [1:0] STORE_FIFO0 = 2'h0;
	localparam logic [1:0] STORE_FIFO1 = 2'h1;

endpackage

// ==== trig_tx_timer.sv ====
// One triggered-transmission reload timer.
`timescale 1ns/1ps
`default_nettype none
module trig_tx_timer
	import can_recovery_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Control
	input wire logic tick,
	input wire logic load,
	input wire logic go,
	input wire logic [15:0] reload,
	// Trigger
	output logic fire
);
	typedef struct packed {
		logic run;
		logic [15:0] cnt;
		logic fire;
	} tmr_s;

	tmr_s s_r;
	tmr_s s_nxt;

	assign fire = s_r.fire;

	// Loading reload N gives N+1 ticks before the trigger.
	always_comb begin
		s_nxt = s_r;
		s_nxt.fire = 1'b0;
		if (load) begin
			s_nxt.run = go; // R20
			s_nxt.cnt = reload;
		end else if (s_r.run && tick) begin
			if (s_r.cnt == 16'h0000) begin
				s_nxt.run = 1'b0;
				s_nxt.fire = 1'b1; // R20
			end else begin
				s_nxt.cnt = s_r.cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	chk_fire_at_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_r.fire |-> $past(s_r.cnt) == 16'h0000 && !s_r.run) // R20
		else $error("timer fired before its count ran out");
endmodule
`default_nettype wire

// ==== can_busoff_recovery_ctrl.sv ====
// CAN node bus-off recovery, activity state, flags and receive buffer.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// R1: Flag set wins over software clear
// R2: Interrupt request only on flag rising
// R3: Timeout flag exempt: its clear wins
// R4: Software rereads flag, repeats clear until zero
// R5: Bus-off sets status and halt request
// R6: Software clears halt to resume
// R7: Wait 129 idle runs, then reset counters
// R8: Idle runs counted in receive error counter
// R9: Each idle run sets bit-zero code, flag
// R10: Recovery reports synchronizing, bus-off stays set
// R11: Bus-off clears after 1420 bit times
// R12: No frames accepted during recovery
// R13: Requested transmission held until idle
// R14: Clear status, counters; idle one bit later
// R15: Idle one bit, then receive or transmit
// R16: Store only DLC bytes, keep others
// R17: Software uses only DLC bytes
// R18: Timeout reload needs new-frame enable
// R19: Software enables new-frame interrupt per store
// R20: Timer counts reload plus one, triggers
// R21: Software programs reload as count minus one
// R22: Dominant bit restarts recessive run count
module can_busoff_recovery_ctrl
	import can_recovery_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// CAN pins
	input wire logic can_rx,
	output logic can_tx,
	// Protocol engine events
	input wire logic tx_err_evt,
	input wire logic rx_err_evt,
	input wire logic rx_frame_valid,
	input wire logic [3:0] rx_dlc,
	input wire logic [63:0] rx_data,
	input wire logic [1:0] rx_store,
	// Status and requests
	output logic [1:0] activity_state,
	output logic busoff_status_bit,
	output logic tx_start,
	output logic [3:0] irq_req
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic rx_s1;
		logic rx_s2;
		logic [15:0] bit_cnt;
		logic [3:0] run;
		act_e act;
		logic idle_held;
		logic [7:0] occ;
		logic [1:0] rstep;
		logic halt;
		logic bo;
		logic [2:0] lec;
		logic [7:0] tec;
		logic [7:0] rec;
		logic tx_pend;
		logic [3:0] fl;
		logic [4:0] ie;
		logic [15:0] to_reload;
		logic teie;
		logic [15:0] to_cnt;
		logic ntcc_src;
		logic [7:0] ntcc_pre;
		logic [7:0] pre_cnt;
		logic [15:0] bit_cfg;
		logic [2:0][15:0] tt_reload;
		logic [7:0][7:0] rx_buf;
		logic [3:0] rx_dlc;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic [3:0] irq;
		logic tx_start;
		logic can_tx;
	} ctl_s;

	ctl_s s_r;
	ctl_s s_nxt;
	logic [2:0] tt_load;
	logic [2:0] tt_fire;
	logic tt_tick;

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign can_tx = s_r.can_tx;
	assign activity_state = s_r.act;
	assign busoff_status_bit = s_r.bo;
	assign tx_start = s_r.tx_start;
	assign irq_req = s_r.irq;

	// ****************************************************************
	// Triggered-transmission timers
	// ****************************************************************
	genvar g;
	for (g = 0; g < 3; g++) begin : g_tt
		trig_tx_timer u_tmr (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.tick(tt_tick),
			.load(tt_load[g]),
			.go(pwdata[TT_GO_BIT]),
			.reload(pwdata[15:0]),
			.fire(tt_fire[g])
		);
	end

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		logic wr;
		logic bit_tick;
		logic pre_tick;
		logic idle_run;
		logic [8:0] tec_sum;
		logic [3:0] fl_set;
		logic [3:0] fl_clr;
		logic nf_en;
		logic [3:0] dlc_eff;
		wr = psel && penable && s_r.pready && pwrite;
		s_nxt = s_r;
		fl_set = 4'h0;
		fl_clr = 4'h0;
		idle_run = 1'b0;
		tec_sum = {1'b0, s_r.tec} + TEC_ERR_STEP;
		dlc_eff = (s_r.rx_dlc > BUF_BYTES) ? BUF_BYTES : s_r.rx_dlc;
		dlc_eff = (rx_dlc > BUF_BYTES) ? BUF_BYTES : rx_dlc;
		s_nxt.tx_start = 1'b0;

		// The first flop only feeds the second, against metastability.
		s_nxt.rx_s1 = can_rx;
		s_nxt.rx_s2 = s_r.rx_s1;

		// Bit time and timer prescaler.
		bit_tick = (s_r.bit_cnt == 16'h0000);
		s_nxt.bit_cnt = bit_tick ? s_r.bit_cfg - 16'h0001
			: s_r.bit_cnt - 16'h0001;
		pre_tick = (s_r.pre_cnt == 8'h00);
		s_nxt.pre_cnt = pre_tick ? s_r.ntcc_pre : s_r.pre_cnt - 8'h01;
		tt_tick = s_r.ntcc_src ? pre_tick : bit_tick;

		// Runs of eleven recessive bits.
		if (bit_tick) begin
			if (!s_r.rx_s2) begin
				s_nxt.run = 4'h0; // R22
			end else if (s_r.run == IDLE_BITS - 4'h1) begin
				s_nxt.run = 4'h0;
				idle_run = 1'b1;
			end else begin
				s_nxt.run = s_r.run + 4'h1;
			end
		end

		// Activity state machine.
		case (s_r.act)
			ACT_SYNC: begin
				if (s_r.halt) begin
					s_nxt.run = 4'h0;
				end else if (s_r.bo) begin
					if (s_r.rstep == 2'h0 && idle_run) begin
						s_nxt.occ = s_r.occ + 8'h01;
						s_nxt.rec = s_r.occ + 8'h01; // R8
						s_nxt.lec = LEC_BIT0; // R9
						fl_set[FL_PE] = 1'b1; // R9
						if (s_r.occ + 8'h01 == RECOV_OCC) begin
							s_nxt.rstep = 2'h1; // R7
						end
					end else if (s_r.rstep == 2'h1 && bit_tick) begin
						s_nxt.bo = 1'b0; // R11
						s_nxt.tec = 8'h00; // R14
						s_nxt.rec = 8'h00; // R14
						s_nxt.occ = 8'h00;
						s_nxt.rstep = 2'h2;
					end
				end else if (s_r.rstep == 2'h2) begin
					if (bit_tick) begin
						s_nxt.act = ACT_IDLE; // R14
						s_nxt.idle_held = 1'b0;
						s_nxt.rstep = 2'h0;
					end
				end else if (idle_run) begin
					s_nxt.act = ACT_IDLE;
					s_nxt.idle_held = 1'b0;
				end
			end
			ACT_IDLE: begin
				if (bit_tick) begin
					s_nxt.idle_held = 1'b1;
					if (s_r.idle_held && !s_r.rx_s2) begin
						s_nxt.act = ACT_RX; // R15
					end else if (s_r.idle_held && s_r.tx_pend) begin
						s_nxt.act = ACT_TX; // R15
						s_nxt.tx_pend = 1'b0;
						s_nxt.tx_start = 1'b1; // R13
					end
				end
			end
			ACT_RX, ACT_TX: begin
				if (idle_run) begin
					s_nxt.act = ACT_IDLE;
					s_nxt.idle_held = 1'b0;
				end
			end
			default: begin
				s_nxt.act = ACT_SYNC;
			end
		endcase

		// Only the start of frame is driven here, dominant for one clock cycle rather than a whole bit time.
		s_nxt.can_tx = !(s_r.act == ACT_TX && s_r.tx_start);

		// Error counters and bus-off entry.
		if (!s_r.bo && tx_err_evt) begin
			if (tec_sum > TEC_LIMIT) begin
				s_nxt.bo = 1'b1; // R5
				s_nxt.halt = 1'b1; // R5
				s_nxt.act = ACT_SYNC; // R10
				s_nxt.tec = 8'hff;
				s_nxt.occ = 8'h00;
				s_nxt.rstep = 2'h0;
			end else begin
				s_nxt.tec = tec_sum[7:0];
			end
		end
		if (!s_r.bo && rx_err_evt && s_r.rec < REC_MAX) begin
			s_nxt.rec = s_r.rec + 8'h01;
		end

		// Frames are refused while halted or recovering.
		if (rx_frame_valid && !s_r.bo && !s_r.halt) begin // R12
			s_nxt.rx_dlc = rx_dlc;
			for (int i = 0; i < 8; i++) begin
				if (4'(i) < dlc_eff) begin
					s_nxt.rx_buf[i] = rx_data[8*i +: 8]; // R16
				end
			end
			fl_set[FL_NF] = 1'b1;
			case (rx_store)
				STORE_FIFO0: nf_en = s_r.ie[IE_F0];
				STORE_FIFO1: nf_en = s_r.ie[IE_F1];
				default: nf_en = s_r.ie[IE_DB];
			endcase
			// Known quirk: reload on a frame only with its enable set.
			if (nf_en) begin
				s_nxt.to_cnt = s_r.to_reload; // R18
			end
		end else begin
			nf_en = 1'b0;
		end

		// Receive timeout counter.
		if (s_r.to_reload != 16'h0000 && bit_tick && !nf_en) begin
			if (s_r.to_cnt == 16'h0000) begin
				fl_set[FL_TO] = 1'b1; // R18
				s_nxt.to_cnt = s_r.to_reload;
			end else begin
				s_nxt.to_cnt = s_r.to_cnt - 16'h0001;
			end
		end

		if (|tt_fire) begin
			s_nxt.tx_pend = 1'b1;
			fl_set[FL_TT] = 1'b1;
		end

		// Register writes.
		tt_load = 3'h0;
		if (wr) begin
			case (paddr)
				OFS_CTRL: begin
					if (!s_nxt.bo || s_r.bo) begin
						s_nxt.halt = pwdata[CTRL_HALT_BIT] || s_nxt.halt
							&& !s_r.halt; // R5
					end
					if (pwdata[CTRL_HALT_BIT]) begin
						s_nxt.act = ACT_SYNC;
					end
					if (pwdata[CTRL_TXREQ_BIT]) begin
						s_nxt.tx_pend = 1'b1; // R13
					end
				end
				OFS_FLAGS: fl_clr = pwdata[3:0];
				OFS_IE: s_nxt.ie = pwdata[4:0];
				OFS_RXTO: begin
					s_nxt.to_reload = pwdata[15:0];
					s_nxt.to_cnt = pwdata[15:0];
					s_nxt.teie = pwdata[RXTO_TEIE_BIT];
				end
				OFS_NTCC: begin
					s_nxt.ntcc_src = pwdata[NTCC_SRC_BIT];
					s_nxt.ntcc_pre = pwdata[NTCC_PRE_LSB +: 8];
				end
				OFS_BITCFG: begin
					if (pwdata[15:0] != 16'h0000) begin
						s_nxt.bit_cfg = pwdata[15:0];
					end
				end
				OFS_TT_A, OFS_TT_B, OFS_TT_C: begin
					tt_load[paddr[3:2]] = 1'b1; // R20
					s_nxt.tt_reload[paddr[3:2]] = pwdata[15:0];
				end
				default: begin
				end
			endcase
		end

		// Hardware sets beat a clear, except for the timeout flag.
		s_nxt.fl = (s_r.fl & ~fl_clr) | fl_set; // R1 R3
		s_nxt.fl[FL_TO] = (s_r.fl[FL_TO] | fl_set[FL_TO])
			& ~fl_clr[FL_TO]; // R3
		s_nxt.irq = s_nxt.fl & ~s_r.fl & {s_r.ie[IE_TT],
			s_r.ie[IE_F0] | s_r.ie[IE_F1] | s_r.ie[IE_DB],
			s_r.teie, s_r.ie[IE_PE]}; // R2

		// APB answer: one wait state, read data captured in setup.
		s_nxt.pready = psel && penable && !s_r.pready;
		if (psel && !penable) begin
			s_nxt.pslverr = 1'b0;
			case (paddr)
				OFS_CTRL: s_nxt.prdata = {30'h0, s_r.tx_pend, s_r.halt};
				OFS_STATUS: s_nxt.prdata = {24'h0, s_r.bo, 2'h0,
					s_r.act, s_r.lec};
				OFS_ECR: s_nxt.prdata = {16'h0, s_r.rec, s_r.tec};
				OFS_FLAGS: s_nxt.prdata = {28'h0, s_r.fl};
				OFS_IE: s_nxt.prdata = {27'h0, s_r.ie};
				OFS_RXTO: s_nxt.prdata = {15'h0, s_r.teie, s_r.to_reload};
				OFS_NTCC: s_nxt.prdata = {20'h0, s_r.ntcc_pre, 3'h0,
					s_r.ntcc_src};
				OFS_BITCFG: s_nxt.prdata = {16'h0, s_r.bit_cfg};
				OFS_TT_A, OFS_TT_B, OFS_TT_C: s_nxt.prdata = {16'h0,
					s_r.tt_reload[paddr[3:2]]};
				OFS_RXBUF_LO: s_nxt.prdata = s_r.rx_buf[3:0];
				OFS_RXBUF_HI: s_nxt.prdata = s_r.rx_buf[7:4];
				OFS_RXINFO: s_nxt.prdata = {28'h0, s_r.rx_dlc};
				default: begin
					s_nxt.prdata = 32'h0;
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.halt <= HALT_RST;
			s_r.bit_cfg <= BITCFG_RST;
			s_r.can_tx <= 1'b1;
			s_r.rx_s1 <= 1'b1;
			s_r.rx_s2 <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	chk_set_over_clear: assert property (s_r.act == ACT_SYNC && s_r.bo
		&& s_nxt.lec == LEC_BIT0 && s_r.rstep == 2'h0
		&& s_nxt.occ != s_r.occ |=> s_r.fl[FL_PE]) // R1
		else $error("protocol error flag lost to a clear");
	chk_irq_on_rise: assert property (s_r.irq[FL_PE]
		|-> s_r.fl[FL_PE] && !$past(s_r.fl[FL_PE])) // R2
		else $error("request without a flag rising edge");
	chk_timeout_clear: assert property (psel && penable && pready
		&& pwrite && paddr == OFS_FLAGS && pwdata[FL_TO]
		|=> !s_r.fl[FL_TO]) // R3
		else $error("timeout flag survived its clear");
	chk_busoff_halt: assert property ($rose(s_r.bo)
		|-> s_r.halt && s_r.act == ACT_SYNC) // R5
		else $error("bus-off entered without halt");
	chk_run_count_bit0: assert property (s_r.bo && $changed(s_r.occ)
		&& s_r.occ != 8'h00 |-> s_r.lec == LEC_BIT0
		&& s_r.rec == s_r.occ) // R8
		else $error("idle run not counted as bit-zero error");
	chk_recov_sync: assert property (s_r.bo
		|-> s_r.act == ACT_SYNC && s_r.occ <= RECOV_OCC) // R10
		else $error("activity not synchronizing in recovery");
	chk_no_rx_recov: assert property (rx_frame_valid && s_r.bo
		|=> $stable(s_r.rx_buf) && $stable(s_r.rx_dlc)) // R12
		else $error("frame accepted during recovery");
	chk_no_tx_recov: assert property (s_r.tx_start
		|-> !s_r.bo && $past(s_r.act) == ACT_IDLE
		&& $past(s_r.idle_held)) // R13
		else $error("transmission started outside idle");
	chk_recov_clear: assert property ($fell(s_r.bo)
		|-> s_r.tec == 8'h00 && s_r.rec == 8'h00
		##1 s_r.act == ACT_SYNC) // R14
		else $error("counters not cleared at recovery end");
	chk_dominant_restart: assert property (s_r.bit_cnt == 16'h0000
		&& !s_r.rx_s2 |=> s_r.run == 4'h0) // R22
		else $error("dominant bit did not restart the run");

	cov_recovery_done: cover property ($fell(s_r.bo));
	cov_held_tx: cover property (s_r.bo && s_r.tx_pend
		##[1:1000] s_r.tx_start);
	cov_timeout_irq: cover property (s_r.irq[FL_TO]);
endmodule
`default_nettype wire

// ==== can_peer_node.sv ====
// Model of the other nodes that share the CAN bus with the controller.
`timescale 1ns/1ps
`default_nettype none
module can_peer_node (
	// Clock
	input wire logic ref_clk,
	// Bus side
	input wire logic node_tx,
	input wire logic dom_go,
	input wire logic [15:0] dom_cycles,
	output logic bus_level
);
	// ****************************************************************
	// Wired-AND bus
	// ****************************************************************
	int hold_cnt = 0;
	// A dominant burst from another node overrides our recessive level.
	always @(posedge ref_clk) begin
		if (dom_go)
			hold_cnt <= int'(dom_cycles);
		else if (hold_cnt > 0)
			hold_cnt <= hold_cnt - 1;
	end
	// The bus idles recessive, so a released line reads one.
	assign bus_level = node_tx & (hold_cnt == 0);
endmodule
`default_nettype wire

// ==== tb_can_busoff_recovery_ctrl.sv ====
// Self-checking bench for the bus-off recovery controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module tb_can_busoff_recovery_ctrl
	import can_recovery_pkg::*;
;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	// A short bit time keeps the 1420-bit recovery well inside the run.
	localparam int BT = 4;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dom_go = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, slv, can_rx, can_tx, tx_start, busoff_status_bit;
	logic tx_err_evt = 1'b0, rx_err_evt = 1'b0, rx_frame_valid = 1'b0;
	logic [3:0] rx_dlc = 4'h0, irq_req;
	logic [63:0] rx_data = 64'h0, buf_exp;
	logic [1:0] rx_store = 2'h0, activity_state;
	logic [7:0] r1;
	int failures = 0, tests_run = 0, n, pe_irq = 0, tt_irq = 0, tx_early = 0;
	time t_clr;

	always #50 ref_clk = ~ref_clk;

	can_busoff_recovery_ctrl i_can_busoff_recovery_ctrl (.ref_clk(ref_clk),
		.rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .can_rx(can_rx), .can_tx(can_tx),
		.tx_err_evt(tx_err_evt), .rx_err_evt(rx_err_evt),
		.rx_frame_valid(rx_frame_valid), .rx_dlc(rx_dlc), .rx_data(rx_data),
		.rx_store(rx_store), .activity_state(activity_state),
		.busoff_status_bit(busoff_status_bit), .tx_start(tx_start),
		.irq_req(irq_req));

	can_peer_node i_can_peer_node (.ref_clk(ref_clk), .node_tx(can_tx),
		.dom_go(dom_go), .dom_cycles(16'(6 * BT)), .bus_level(can_rx));

	always @(negedge ref_clk) begin
		if (irq_req[0] === 1'b1)
			pe_irq++;
		if (irq_req[3] === 1'b1)
			tt_irq++;
		if (tx_start === 1'b1 && busoff_status_bit !== 1'b0)
			tx_early++;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Pready and read data are taken at the edge that samples pready.
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rdat = prdata;
		slv = pslverr;
		if (k >= 20)
			failures++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic wait_for(input int sel, input int lim);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (!(sel == 0 ? busoff_status_bit === 1'b0 :
			sel == 1 ? activity_state === ACT_IDLE :
			sel == 2 ? tx_start === 1'b1 : irq_req[3] === 1'b1) && n < lim);
	endtask

	task automatic pulse_err(input int cnt, input logic rx_side);
		repeat (cnt) begin
			if (rx_side)
				rx_err_evt <= 1'b1;
			else
				tx_err_evt <= 1'b1;
			@(posedge ref_clk);
			rx_err_evt <= 1'b0;
			tx_err_evt <= 1'b0;
			@(posedge ref_clk);
		end
	endtask

	function automatic logic [63:0] merge(logic [63:0] o, logic [63:0] d,
			logic [3:0] dl);
		for (int i = 0; i < 8; i++)
			if (i < int'(dl))
				o[i*8 +: 8] = d[i*8 +: 8];
		return o;
	endfunction

	task automatic frame(input logic [3:0] dl, input logic take);
		logic [63:0] d;
		d = {$urandom(), $urandom()};
		rx_dlc <= dl;
		rx_data <= d;
		rx_store <= 2'($urandom_range(0, 3));
		rx_frame_valid <= 1'b1;
		@(posedge ref_clk);
		rx_frame_valid <= 1'b0;
		@(posedge ref_clk);
		if (take)
			buf_exp = merge(buf_exp, d, dl);
		rd(OFS_RXBUF_LO);
		`CHK(rdat, buf_exp[31:0])
		rd(OFS_RXBUF_HI);
		`CHK(rdat, buf_exp[63:32])
	endtask

	task automatic test_done();
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#(40000 * 100);
		failures++;
		test_done();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		void'($urandom(20184));
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(OFS_CTRL);
		`CHK(rdat[CTRL_HALT_BIT], HALT_RST)
		rd(OFS_STATUS);
		`CHK(rdat[7:3], 5'h00)
		apb(1'b1, 8'h2c, 32'h1);
		`CHK({slv, rdat}, {1'b1, 32'h0})
		wr(OFS_BITCFG, BT);
		wr(OFS_IE, 32'h1f);
		wr(OFS_NTCC, 32'h0);
		wr(OFS_CTRL, 32'h0);
		wait_for(1, 40 * BT);
		`CHK(activity_state, ACT_IDLE)
		frame(4'h8, 1'b1);
		for (int i = 0; i < 10; i++)
			frame(i == 3 ? 4'hf : i == 5 ? 4'h0 : 4'($urandom_range(0, 8)), 1'b1);
		n = $urandom_range(1, 5);
		pulse_err(n, 1'b1);
		rd(OFS_ECR);
		`CHK(rdat[15:8], 8'(n))
		// Timer B is loaded without its go bit and must stay silent.
		wr(OFS_TT_B, 32'h0000_0002);
		wr(OFS_TT_A, 32'h8000_0005);
		wait_for(3, 20 * BT);
		`CHK(n >= 5 * BT && n <= 6 * BT + 4, 1'b1)
		repeat (10 * BT) @(posedge ref_clk);
		`CHK(tt_irq, 1)
		wait_for(1, 40 * BT);
		pulse_err(31, 1'b0);
		rd(OFS_ECR);
		`CHK({busoff_status_bit, rdat[7:0]}, {1'b0, 8'hf8})
		pulse_err(1, 1'b0);
		`CHK({busoff_status_bit, activity_state}, {1'b1, ACT_SYNC})
		rd(OFS_CTRL);
		`CHK(rdat[CTRL_HALT_BIT], 1'b1)
		frame(4'h8, 1'b0);
		wr(OFS_FLAGS, 32'hf);
		pe_irq = 0;
		wr(OFS_CTRL, 32'h2);
		t_clr = $time;
		repeat (30 * BT) @(posedge ref_clk);
		rd(OFS_STATUS);
		`CHK({rdat[7], rdat[4:0]}, {1'b1, 2'h0, LEC_BIT0})
		rd(OFS_ECR);
		r1 = rdat[15:8];
		repeat (22 * BT - 4) @(posedge ref_clk);
		rd(OFS_ECR);
		`CHK(rdat[15:8] - r1, 8'h02)
		frame(4'h8, 1'b0);
		wait_for(0, 1500 * BT);
		n = int'(($time - t_clr) / 100);
		`CHK(n >= 1419 * BT && n <= 1421 * BT + 6, 1'b1)
		wait_for(1, 4 * BT);
		`CHK(n >= BT - 1 && n <= BT + 1, 1'b1)
		wait_for(2, 4 * BT);
		`CHK(n >= BT - 1 && n <= 2 * BT + 2, 1'b1)
		`CHK(activity_state, ACT_TX)
		`CHK(tx_early, 0)
		rd(OFS_ECR);
		`CHK(rdat[15:0], 16'h0000)
		`CHK(pe_irq, 1)
		for (int i = 0; i < 4; i++) begin
			wr(OFS_FLAGS, 32'h1);
			rd(OFS_FLAGS);
			if (rdat[FL_PE] === 1'b0)
				break;
		end
		`CHK(rdat[FL_PE], 1'b0)
		wait_for(1, 40 * BT);
		pulse_err(32, 1'b0);
		wr(OFS_CTRL, 32'h0);
		t_clr = $time;
		repeat (60 * BT) @(posedge ref_clk);
		dom_go <= 1'b1;
		@(posedge ref_clk);
		dom_go <= 1'b0;
		wait_for(0, 1500 * BT);
		n = int'(($time - t_clr) / 100);
		`CHK(n >= 1425 * BT && n <= 1440 * BT, 1'b1)
		test_done();
	end
endmodule
`default_nettype wire
